// ==== rtl/wdt_aux_pkg.sv ====
package wdt_aux_pkg;

    // ****************************************************************
    // clocking
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 50;
    // the oscillator is the system clock itself
    localparam int OSC_PERIOD_NS = 50;
    localparam int MACHINE_CYCLE_OSC = 12;
    localparam int STROBE_DIV_OSC = 6;
    localparam int RESET_PULSE_OSC = 98;
    localparam int MACHINE_CYCLE_CLKS = (MACHINE_CYCLE_OSC * OSC_PERIOD_NS) / CLK_PERIOD_NS;
    localparam int STROBE_DIV_CLKS = (STROBE_DIV_OSC * OSC_PERIOD_NS) / CLK_PERIOD_NS;
    localparam int RESET_PULSE_CLKS =
        (RESET_PULSE_OSC * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_HIGH_CLKS = 2;

    // ****************************************************************
    // special function register map
    // ****************************************************************
    localparam logic [7:0] AUX_CONTROL_ADDR = 8'h8e;
    localparam logic [7:0] WATCHDOG_SERVICE_ADDR = 8'ha6;
    localparam logic [7:0] UNLOCK_FIRST = 8'h1e;
    localparam logic [7:0] UNLOCK_SECOND = 8'he1;
    localparam int AUX_STROBE_SUPPRESS_BIT = 0;
    localparam int AUX_RESET_OUT_DISABLE_BIT = 3;
    localparam int AUX_IDLE_HALT_BIT = 4;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ****************************************************************
    // watchdog counter
    // ****************************************************************
    localparam int WDT_WIDTH = 14;
    localparam logic [WDT_WIDTH-1:0] WDT_LIMIT = 14'h3fff;
    localparam logic [WDT_WIDTH-1:0] WDT_ZERO = 14'h0000;

    typedef struct packed {
        logic idle_halt_bit;
        logic reset_out_disable;
        logic strobe_suppress;
    } aux_fields_t;

    localparam aux_fields_t AUX_RESET = '{idle_halt_bit: 1'b0, reset_out_disable: 1'b0,
                                          strobe_suppress: 1'b0};

    typedef enum logic [1:0] {WD_OFF, WD_RUN, WD_PULSE} wd_mode_t;

    typedef struct packed {
        logic we;
        logic re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    // wrapping counter step, shared by every divider in the block
    function automatic logic [7:0] wrap_inc(input logic [7:0] value, input logic [7:0] last);
        logic [7:0] result;
        result = (value >= last) ? 8'h00 : value + 8'h01;
        return result;
    endfunction

endpackage

// ==== rtl/strobe_gen.sv ====
module strobe_gen
    import wdt_aux_pkg::*;
#(
    parameter int DIV_CLKS = STROBE_DIV_CLKS,
    parameter int HIGH_CLKS = STROBE_HIGH_CLKS
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic suppress,
    input wire logic ext_move_active,
    output logic strobe
);
    import wdt_aux_pkg::*;

    typedef struct packed {
        logic [7:0] phase;
        logic out;
    } strobe_state_t;

    localparam logic [7:0] LAST_PHASE = 8'(DIV_CLKS - 1);
    localparam logic [7:0] HIGH_PHASES = 8'(HIGH_CLKS);

    strobe_state_t state_reg;
    strobe_state_t state_next;

    // ****************************************************************
    // divider and gating
    // ****************************************************************
    always_comb
    begin
        state_next = state_reg;
        state_next.phase = wrap_inc(state_reg.phase, LAST_PHASE);
        // free-running phase keeps the strobe aligned when suppression is lifted
        if (suppress)
        begin
            state_next.out = ext_move_active && (state_next.phase < HIGH_PHASES); // see R9
        end
        else
        begin
            state_next.out = state_next.phase < HIGH_PHASES; // see R9
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign strobe = state_reg.out;

endmodule // strobe_gen

// ==== rtl/watchdog_aux.sv ====
// How it works
// R1: after any reset the watchdog is off and its counter stands still until software arms it (a pin reset on RST_PIN_IN leaves the mode as it was).
// R2: writing 1e then e1 to the service register arms the watchdog.
// R3: an armed watchdog steps a 14-bit counter once per machine cycle while the clock runs.
// R4: writing the same pair while armed clears the counter, which keeps counting.
// R5: a counter that reaches 3fff is an overflow and resets the whole chip.
// R6: no write can turn an armed watchdog off; only a reset or an overflow does.
// R7: the service register is write-only and the counter can be neither read nor loaded.
// R8: an overflow drives a high pulse on the reset pin lasting 98 oscillator periods.
// R9: strobe suppress 0 gives a strobe at a sixth of the clock, 1 only during external moves.
// R10: with idle halt at 0, its reset value, the watchdog counts on through idle.
// R11: with idle halt at 1, the count freezes in idle and resumes from that value after it.
// R12: in power-down the clock is stopped, so the watchdog does not count.
// R13: after a wake by level interrupt the count waits until the interrupt line is high again.
// R14: reset out disable is aux bit 3; at 0 an overflow drives the pin, at 1 the pin is input only.
// R15: e1 counts only right after 1e; any other value written breaks the sequence.
module watchdog_aux
    import wdt_aux_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic SFR_WE,
    input wire logic SFR_RE,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    input wire logic IDLE_MODE,
    input wire logic POWER_DOWN,
    input wire logic EXT_INT_N,
    input wire logic EXT_MOVE_ACTIVE,
    input wire logic RST_PIN_IN,
    output logic RST_PIN_OUT,
    output logic RST_PIN_OE_N,
    output logic CHIP_RESET,
    output logic WDT_ARMED,
    output logic ALE_OUT
);
    import wdt_aux_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        wd_mode_t mode;
        logic [WDT_WIDTH-1:0] watchdog_counter;
        logic [7:0] prescale;
        logic [7:0] pulse_count;
        logic drive_pin;
        logic seq_first_seen;
        aux_fields_t aux;
        logic [7:0] rdata;
        logic int_meta;
        logic int_sync;
        logic pin_meta;
        logic pin_sync;
        logic pd_wait;
    } wd_state_t;

    localparam logic [7:0] PRESCALE_LAST = 8'(MACHINE_CYCLE_CLKS - 1);
    localparam logic [7:0] PULSE_LAST = 8'(RESET_PULSE_CLKS - 1);

    wd_state_t state_reg;
    wd_state_t state_next;
    sfr_req_t req;
    logic svc_write;
    logic aux_write;
    logic unlock_done;
    logic count_enable;
    logic machine_tick;

    assign req = '{we: SFR_WE, re: SFR_RE, addr: SFR_ADDR, wdata: SFR_WDATA};

    // ****************************************************************
    // decode
    // ****************************************************************
    always_comb
    begin
        svc_write = req.we && (req.addr == WATCHDOG_SERVICE_ADDR);
        aux_write = req.we && (req.addr == AUX_CONTROL_ADDR);
        // second byte only completes the pair when the first came just before it
        unlock_done = svc_write && state_reg.seq_first_seen
            && (req.wdata == UNLOCK_SECOND); // see R15
        // the clock stands still in power-down; the prescaler freezes with it
        count_enable = (state_reg.mode == WD_RUN)
            && !POWER_DOWN // see R12
            && !state_reg.pd_wait // see R13
            && !(IDLE_MODE && state_reg.aux.idle_halt_bit); // see R10 see R11
        machine_tick = count_enable && (state_reg.prescale == PRESCALE_LAST);
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        state_next = state_reg;

        // pin inputs pass two flops first
        state_next.int_meta = EXT_INT_N;
        state_next.int_sync = state_reg.int_meta;
        state_next.pin_meta = RST_PIN_IN;
        state_next.pin_sync = state_reg.pin_meta;

        // a wake by level interrupt holds the count until the line returns high
        if (POWER_DOWN)
        begin
            state_next.pd_wait = 1'b1; // see R13
        end
        else if (state_reg.int_sync)
        begin
            state_next.pd_wait = 1'b0; // see R13
        end

        // unlock sequence tracking
        if (svc_write)
        begin
            state_next.seq_first_seen = (req.wdata == UNLOCK_FIRST); // see R15
        end

        // register writes: aux only, the service register holds no data
        if (aux_write)
        begin
            state_next.aux.idle_halt_bit = req.wdata[AUX_IDLE_HALT_BIT];
            state_next.aux.reset_out_disable = req.wdata[AUX_RESET_OUT_DISABLE_BIT]; // see R14
            state_next.aux.strobe_suppress = req.wdata[AUX_STROBE_SUPPRESS_BIT];
        end

        // reads: service register and counter never show, reserved bits read zero
        state_next.rdata = READ_ZERO; // see R7
        if (req.re && (req.addr == AUX_CONTROL_ADDR))
        begin
            state_next.rdata[AUX_IDLE_HALT_BIT] = state_reg.aux.idle_halt_bit;
            state_next.rdata[AUX_RESET_OUT_DISABLE_BIT] = state_reg.aux.reset_out_disable;
            state_next.rdata[AUX_STROBE_SUPPRESS_BIT] = state_reg.aux.strobe_suppress;
        end

        if (count_enable)
        begin
            state_next.prescale = wrap_inc(state_reg.prescale, PRESCALE_LAST);
        end

        case (state_reg.mode)
            WD_OFF:
            begin
                // counter stays put until armed
                state_next.watchdog_counter = WDT_ZERO; // see R1
                state_next.prescale = 8'h00; // see R1
                if (unlock_done)
                begin
                    state_next.mode = WD_RUN; // see R2
                end
            end
            WD_RUN:
            begin
                // no path back to off except overflow or reset
                if (unlock_done)
                begin
                    state_next.watchdog_counter = WDT_ZERO; // see R4
                end
                else if (state_reg.watchdog_counter == WDT_LIMIT)
                begin
                    // overflow resets the chip, so aux and sequence return to defaults
                    state_next.mode = WD_PULSE; // see R5 see R6
                    state_next.watchdog_counter = WDT_ZERO;
                    state_next.prescale = 8'h00;
                    state_next.pulse_count = 8'h00;
                    state_next.drive_pin = !state_reg.aux.reset_out_disable; // see R14
                    state_next.aux = AUX_RESET;
                    state_next.seq_first_seen = 1'b0;
                end
                else if (machine_tick)
                begin
                    state_next.watchdog_counter = state_reg.watchdog_counter + 14'h0001; // see R3
                end
            end
            WD_PULSE:
            begin
                // the chip is in reset: ignore all register traffic
                state_next.aux = AUX_RESET;
                state_next.seq_first_seen = 1'b0;
                state_next.rdata = READ_ZERO;
                state_next.pulse_count = wrap_inc(state_reg.pulse_count, PULSE_LAST); // see R8
                if (state_reg.pulse_count == PULSE_LAST)
                begin
                    state_next.mode = WD_OFF; // see R1 see R8
                    state_next.drive_pin = 1'b0;
                end
            end
            default:
            begin
                state_next.mode = WD_OFF;
            end
        endcase
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            state_reg.mode <= WD_OFF; // see R1 see R6
            state_reg.watchdog_counter <= WDT_ZERO;
            state_reg.prescale <= 8'h00;
            state_reg.pulse_count <= 8'h00;
            state_reg.drive_pin <= 1'b0;
            state_reg.seq_first_seen <= 1'b0;
            state_reg.aux <= AUX_RESET; // see R10
            state_reg.rdata <= READ_ZERO;
            state_reg.int_meta <= 1'b1;
            state_reg.int_sync <= 1'b1;
            state_reg.pin_meta <= 1'b0;
            state_reg.pin_sync <= 1'b0;
            state_reg.pd_wait <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // address latch strobe
    // ****************************************************************
    strobe_gen #(
        .DIV_CLKS(STROBE_DIV_CLKS),
        .HIGH_CLKS(STROBE_HIGH_CLKS)
    ) u_strobe (
        .clk(CLK_SYS),
        .rst(RST || (state_reg.mode == WD_PULSE)),
        .suppress(state_reg.aux.strobe_suppress),
        .ext_move_active(EXT_MOVE_ACTIVE),
        .strobe(ALE_OUT)
    );

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign SFR_RDATA = state_reg.rdata;
    // pin is driven only for the pulse and only when reset out is enabled
    assign RST_PIN_OUT = state_reg.drive_pin; // see R8 see R14
    assign RST_PIN_OE_N = !state_reg.drive_pin; // see R14
    // an external high on the pin also resets the chip, even while it is input only
    assign CHIP_RESET = (state_reg.mode == WD_PULSE) || state_reg.pin_sync; // see R5
    assign WDT_ARMED = (state_reg.mode == WD_RUN);

endmodule // watchdog_aux

// ==== dv/watchdog_aux_checker.sv ====
module watchdog_aux_checker
    import wdt_aux_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic SFR_WE,
    input wire logic SFR_RE,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic [7:0] SFR_RDATA,
    input wire logic RST_PIN_OUT,
    input wire logic RST_PIN_OE_N,
    input wire logic CHIP_RESET,
    input wire logic WDT_ARMED,
    input wire logic ALE_OUT
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // properties
    // ****************************************************************
    logic [7:0] pulse_cnt_reg;
    logic [7:0] pulse_cnt_next;
    always_comb
    begin
        pulse_cnt_next = RST_PIN_OUT ? pulse_cnt_reg + 8'h01 : 8'h00;
    end
    always_ff @(posedge CLK_SYS)
    begin
        pulse_cnt_reg <= RST ? 8'h00 : pulse_cnt_next;
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    sequence unlock_first;
        SFR_WE && SFR_ADDR == WATCHDOG_SERVICE_ADDR && SFR_WDATA == UNLOCK_FIRST && !CHIP_RESET;
    endsequence
    sequence unlock_second;
        SFR_WE && SFR_ADDR == WATCHDOG_SERVICE_ADDR && SFR_WDATA == UNLOCK_SECOND && !CHIP_RESET;
    endsequence
    a_reset_clears: assert property (disable iff (1'b0) RST |=> !WDT_ARMED && RST_PIN_OE_N
        && SFR_RDATA == READ_ZERO) else $error("reset left state behind");
    a_arm_on_pair: assert property (unlock_first ##1 unlock_second |=> WDT_ARMED)
        else $error("pair did not arm");
    a_arm_cause: assert property ($rose(WDT_ARMED) |-> $past(SFR_WE)
        && $past(SFR_WDATA) == UNLOCK_SECOND) else $error("armed without second byte");
    a_no_disable: assert property (WDT_ARMED |=> WDT_ARMED || CHIP_RESET)
        else $error("armed watchdog turned off");
    a_pulse_from_armed: assert property ($rose(RST_PIN_OUT) |-> $past(WDT_ARMED))
        else $error("pulse without armed watchdog");
    a_pulse_length: assert property ($fell(RST_PIN_OUT) |-> pulse_cnt_reg == RESET_PULSE_CLKS)
        else $error("reset pulse length wrong");
    a_pin_drive: assert property (!RST_PIN_OE_N |-> RST_PIN_OUT && CHIP_RESET)
        else $error("pin driven outside pulse");
    a_service_unread: assert property (SFR_RE && SFR_ADDR == WATCHDOG_SERVICE_ADDR
        |=> SFR_RDATA == READ_ZERO) else $error("service register readable");
    a_strobe_width: assert property ($rose(ALE_OUT) ##1 ALE_OUT |=> !ALE_OUT)
        else $error("strobe high too long");
endmodule // watchdog_aux_checker

bind watchdog_aux watchdog_aux_checker watchdog_aux_checker_inst (.CLK_SYS(CLK_SYS), .RST(RST),
    .SFR_WE(SFR_WE), .SFR_RE(SFR_RE), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
    .SFR_RDATA(SFR_RDATA), .RST_PIN_OUT(RST_PIN_OUT), .RST_PIN_OE_N(RST_PIN_OE_N),
    .CHIP_RESET(CHIP_RESET), .WDT_ARMED(WDT_ARMED), .ALE_OUT(ALE_OUT));

// ==== dv/cpu_core_model.sv ====
module cpu_core_model
(
    input wire logic clk,
    output logic we,
    output logic re,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // core bus cycles
    // ****************************************************************
    initial
    begin
        we = 1'b0;
        re = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end
    // released lines show the inverse so stale data never looks valid
    task automatic release_bus();
        @(posedge clk);
        #1;
        we = 1'b0;
        re = 1'b0;
        addr = ~addr;
        wdata = ~wdata;
    endtask
    task automatic write_sfr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        we = 1'b1;
        addr = a;
        wdata = d;
        release_bus();
    endtask
    // two back to back writes, used for the unlock pair
    task automatic write_pair(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1);
        @(posedge clk);
        #1;
        we = 1'b1;
        addr = a;
        wdata = d0;
        @(posedge clk);
        #1;
        wdata = d1;
        release_bus();
    endtask
    task automatic read_sfr(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        re = 1'b1;
        addr = a;
        release_bus();
        d = rdata;
    endtask
endmodule // cpu_core_model

// ==== dv/watchdog_with_aux_control_tb_top.sv ====
module watchdog_with_aux_control_tb_top;
    import wdt_aux_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // harness
    // ****************************************************************
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic idle_mode = 1'b0;
    logic power_down = 1'b0;
    logic ext_int_n = 1'b1;
    logic ext_move = 1'b0;
    logic pin_in = 1'b0;
    logic we, re, pin_out, pin_oe_n, chip_reset, armed, ale;
    logic [7:0] addr, wdata, rdata, got;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #25 clk_sys = ~clk_sys;
    cpu_core_model cpu_core_model_inst (.clk(clk_sys), .we(we), .re(re), .addr(addr),
        .wdata(wdata), .rdata(rdata));
    watchdog_aux watchdog_aux_inst (.CLK_SYS(clk_sys), .RST(rst), .SFR_WE(we), .SFR_RE(re),
        .SFR_ADDR(addr), .SFR_WDATA(wdata), .SFR_RDATA(rdata), .IDLE_MODE(idle_mode),
        .POWER_DOWN(power_down), .EXT_INT_N(ext_int_n), .EXT_MOVE_ACTIVE(ext_move),
        .RST_PIN_IN(pin_in), .RST_PIN_OUT(pin_out), .RST_PIN_OE_N(pin_oe_n),
        .CHIP_RESET(chip_reset), .WDT_ARMED(armed), .ALE_OUT(ale));
    task automatic give_verdict();
        $display("compared %0d, mismatched %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // the whole run is about 200 cycles; overflow itself is left to the checker
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_total++;
            give_verdict();
        end
    end
    task automatic check(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic count_ale(input int n, output logic [7:0] hi);
        hi = 8'h00;
        repeat (n)
        begin
            tick(1);
            if (ale === 1'b1)
                hi = hi + 8'h01;
        end
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic test_reset_state();
        check({7'h00, armed}, 8'h00);
        check({6'h00, pin_out, chip_reset}, 8'h00);
        cpu_core_model_inst.read_sfr(AUX_CONTROL_ADDR, got);
        check(got, 8'h00);
        cpu_core_model_inst.read_sfr(WATCHDOG_SERVICE_ADDR, got);
        check(got, 8'h00);
        cpu_core_model_inst.read_sfr(8'h80, got);
        check(got, 8'h00);
    endtask
    task automatic test_broken_pair();
        cpu_core_model_inst.write_pair(WATCHDOG_SERVICE_ADDR, UNLOCK_FIRST, 8'h55);
        cpu_core_model_inst.write_sfr(WATCHDOG_SERVICE_ADDR, UNLOCK_SECOND);
        cpu_core_model_inst.write_pair(WATCHDOG_SERVICE_ADDR, UNLOCK_SECOND, UNLOCK_FIRST);
        tick(2);
        check({7'h00, armed}, 8'h00);
    endtask
    task automatic test_aux_rw();
        cpu_core_model_inst.write_sfr(AUX_CONTROL_ADDR, 8'hff);
        cpu_core_model_inst.read_sfr(AUX_CONTROL_ADDR, got);
        check(got, 8'h19);
        cpu_core_model_inst.write_sfr(AUX_CONTROL_ADDR, 8'h00);
        cpu_core_model_inst.read_sfr(AUX_CONTROL_ADDR, got);
        check(got, 8'h00);
    endtask
    task automatic test_strobe();
        count_ale(60, got);
        check(got, 8'h14);
        cpu_core_model_inst.write_sfr(AUX_CONTROL_ADDR, 8'h01);
        tick(3);
        count_ale(12, got);
        check(got, 8'h00);
        ext_move = 1'b1;
        tick(2);
        count_ale(12, got);
        check(got, 8'h04);
        ext_move = 1'b0;
        cpu_core_model_inst.write_sfr(AUX_CONTROL_ADDR, 8'h00);
    endtask
    task automatic test_arm_hold();
        cpu_core_model_inst.write_pair(WATCHDOG_SERVICE_ADDR, UNLOCK_FIRST, UNLOCK_SECOND);
        tick(1);
        check({7'h00, armed}, 8'h01);
        cpu_core_model_inst.write_pair(WATCHDOG_SERVICE_ADDR, UNLOCK_FIRST, UNLOCK_SECOND);
        tick(1);
        check({7'h00, armed}, 8'h01);
        cpu_core_model_inst.write_sfr(WATCHDOG_SERVICE_ADDR, 8'h00);
        cpu_core_model_inst.write_sfr(AUX_CONTROL_ADDR, 8'h10);
        idle_mode = 1'b1;
        tick(20);
        idle_mode = 1'b0;
        power_down = 1'b1;
        ext_int_n = 1'b0;
        tick(10);
        power_down = 1'b0;
        tick(5);
        ext_int_n = 1'b1;
        tick(5);
        check({7'h00, armed}, 8'h01);
        cpu_core_model_inst.read_sfr(WATCHDOG_SERVICE_ADDR, got);
        check(got, 8'h00);
    endtask
    task automatic test_reset_disarms();
        rst = 1'b1;
        tick(4);
        rst = 1'b0;
        tick(1);
        check({7'h00, armed}, 8'h00);
        check({7'h00, pin_oe_n}, 8'h01);
        // an outside high on the pin reaches chip reset through two flops
        pin_in = 1'b1;
        tick(3);
        check({6'h00, pin_oe_n, chip_reset}, 8'h03);
        pin_in = 1'b0;
        tick(3);
        check({6'h00, pin_out, chip_reset}, 8'h00);
    endtask
    initial
    begin
        tick(16);
        rst = 1'b0;
        test_reset_state();
        test_broken_pair();
        test_aux_rw();
        test_strobe();
        test_arm_hold();
        test_reset_disarms();
        give_verdict();
    end
endmodule // watchdog_with_aux_control_tb_top
